// ==== rtl/dmc_cfg.svh ====
/*
  Offsets, field positions, reset values, mode register codes and timing
  counts for the DDR3 calibration-read and DLL-switch controller.
  Assumes DDR3 command encoding and mode register layout of the attached part.
*/
`ifndef DMC_CFG_SVH
`define DMC_CFG_SVH
// apb register offsets
`define DMC_A_CTRL     12'h000
`define DMC_A_STAT     12'h004
// field positions
`define DMC_F_ERR      3
// operations written to the control register
`define DMC_OP_CAL     2'h1
`define DMC_OP_OFF     2'h2
`define DMC_OP_ON      2'h3
// reset value of the half-period divider: 4 x 25 ns half period, 200 ns CK
`define DMC_DIV_RST    8'h04
// command codes {cs_n, ras_n, cas_n, we_n}
`define DMC_C_DES      4'h8
`define DMC_C_NOP      4'h7
`define DMC_C_MRS      4'h0
`define DMC_C_REF      4'h1
`define DMC_C_RD       4'h5
// mode register values
`define DMC_MR0_CL6    14'h0020
`define DMC_MR0_CLMSK  14'h0074
`define DMC_MR0_OTF    14'h0001
`define DMC_MR0_DLLRST 14'h0100
`define DMC_MR1_DLLOFF 14'h0001
`define DMC_MR2_CWL6   14'h0008
`define DMC_MR2_CWLMSK 14'h0038
`define DMC_MR3_CAL    14'h0004
// timing counts in CK cycles
`define DMC_T_MOD      16'h000c
`define DMC_T_MRD      16'h0004
`define DMC_T_CKSRE    16'h0005
`define DMC_T_CKSRX    16'h0005
// capture window after a calibration read: AL+CL plus burst plus margin
`define DMC_T_RDWIN    16'h0010
`endif

// ==== rtl/dmc_pkg.sv ====
/*
  Types of the DDR3 calibration-read and DLL-switch controller.
  Assumes the constants of dmc_cfg.svh.
*/
package dmc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_M3ON, ST_RD, ST_M3OFF, ST_MR1OFF, ST_SRE, ST_FRQ,
    ST_SRX, ST_MR1ON, ST_DLLRST, ST_MR0, ST_MR2, ST_END
  } dmc_state_e;

  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        odt;
    logic [2:0]  ba;
    logic [13:0] addr;
  } dmc_pins_s;

  typedef struct packed {
    dmc_state_e  state;
    logic        ck;
    logic        ck_n;
    logic [7:0]  divcnt;
    logic [7:0]  div;
    logic [7:0]  newdiv;
    logic [15:0] wait_c;
    logic [15:0] lock_c;
    dmc_pins_s   pins;
    logic        iss;
    logic [1:0]  dq_s1;
    logic [1:0]  dq_s2;
    logic        dqs_s1;
    logic        dqs_s2;
    logic        dqs_d;
    logic        cap;
    logic [3:0]  beats;
    logic [7:0]  dl;
    logic [7:0]  du;
    logic        busy;
    logic        dll_on;
    logic        locked;
    logic        cal_on;
    logic        err;
    logic [1:0]  op;
    logic        chop;
    logic        half;
    logic        otf;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dmc_st_s;
endpackage

// ==== rtl/dmc_host.sv ====
/*
  DDR3 controller slice: calibration pattern reads and DLL on/off switching
  through self-refresh, ordered over an APB slave.
  Assumes the device sits on the command pins, CK is made here by a divider
  of MCLK, DQ and DQS come in asynchronously and are synchronised.
*/
// Contract
// RULE1: device puts calibration bits on bit 0 of both byte lanes
// RULE2: device repeats bit 0 on lines 7..1 or drives them zero
// RULE3: calibration read is issued with column bits 1:0 at zero
// RULE4: eight-beat calibration read keeps address bit 2 zero; beats come 0..7
// RULE5: chopped read returns beats 0..3 for A2 zero, 4..7 for A2 one
// RULE6: A12 selects chop on the fly only when MR0 enables it
// RULE7: device ignores bank bits and other column bits in calibration reads
// RULE8: calibration reads use ordinary read latency and command timing
// RULE9: no calibration read before the DLL is locked
// RULE10: beat 0 is the LSB, beat 7 the MSB of the pattern
// RULE11: location 00 returns alternating 0,1 pattern
// RULE12: NOP registers no command; running operations continue
// RULE13: deselect executes no command; running operations continue
// RULE14: MR1 A0 one disables the DLL until written back to zero
// RULE15: DLL-off mode runs with CL 6 and CWL 6
// RULE16: in DLL-off the read strobe starts at AL+CL-1
// RULE17: DLL off: MR1 A0, tMOD, self-refresh, tCKSRE, new clock, tCKSRX
// RULE18: after exit keep CKE high and ODT low until tMOD passes
// RULE19: after exit wait tXS, reprogram mode registers, then tMOD
// RULE20: DLL on: self-refresh, new clock, tCKSRX, CKE high, ODT low
// RULE21: DLL on: tXS, clear MR1 A0, tMRD, MR0 A8 reset, tMRD, reprogram
// RULE22: after DLL reset wait tMOD, tDLLK before locked-DLL commands
// RULE23: calibration mode is entered by MR3 A2 one with banks idle
// RULE24: device treats read with auto-precharge as plain read in this mode
// RULE25: strobe preamble and postamble as for an array read
`include "dmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dmc_host
  import dmc_pkg::*;
#(
  parameter logic [15:0] TXS_NCK   = 16'h0200,
  parameter logic [15:0] TDLLK_NCK = 16'h0200
) (
  input  wire logic        MCLK,    // system clock, 40 MHz
  input  wire logic        RST,     // synchronous reset, active high
  input  wire logic        PSEL,    // apb select
  input  wire logic        PENABLE, // apb access phase
  input  wire logic        PWRITE,  // apb direction
  input  wire logic [11:0] PADDR,   // apb byte address
  input  wire logic [31:0] PWDATA,  // apb write data
  output logic      [31:0] PRDATA,  // apb read data
  output logic             PREADY,  // apb ready
  output logic             PSLVERR, // apb error, unmapped address
  output logic             CK,      // memory clock
  output logic             CK_N,    // memory clock complement
  output logic             CKE,     // clock enable
  output logic             CS_N,    // chip select
  output logic             RAS_N,   // row strobe
  output logic             CAS_N,   // column strobe
  output logic             WE_N,    // write enable
  output logic      [2:0]  BA,      // bank address
  output logic      [13:0] ADDR,    // address
  output logic             ODT,     // termination control
  input  wire logic [15:0] DQ_IN,   // read data from device
  input  wire logic        DQS_IN   // read strobe from device, lower lane
);
  dmc_st_s    st_ff;
  dmc_st_s    nxt_st;
  logic       tick;
  logic       refuse;
  logic [2:0] idx;
  logic [3:0] blen;
  logic [1:0] wop;

  localparam dmc_st_s ST_RST = '{state: ST_IDLE, div: `DMC_DIV_RST, dll_on: 1'b1,
                                 locked: 1'b1, ck_n: 1'b1,
                                 pins: '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1,
                                         cas_n: 1'b1, we_n: 1'b1, default: '0},
                                 default: '0};

  function automatic dmc_pins_s mk(input logic cke, input logic [3:0] c,
                                   input logic [2:0] ba, input logic [13:0] a);
    dmc_pins_s p;
    p.cke   = cke;
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} = c;
    p.odt   = 1'b0; // RULE18 RULE20
    p.ba    = ba;
    p.addr  = a;
    return p;
  endfunction

  function automatic logic is_cmd(input dmc_pins_s p, input logic [3:0] c);
    return {p.cs_n, p.ras_n, p.cas_n, p.we_n} == c;
  endfunction

  // commands change at the CK falling edge so the device sees them stable
  assign tick = st_ff.ck && (st_ff.divcnt == 8'h00);
  assign wop  = PWDATA[1:0];
  assign idx  = st_ff.beats[2:0] | {st_ff.chop & st_ff.half, 2'b00}; // RULE5 RULE10
  assign blen = st_ff.chop ? 4'h4 : 4'h8;
  assign refuse = st_ff.busy
      || (wop == `DMC_OP_CAL && (!st_ff.locked || !st_ff.dll_on // RULE9
          || (PWDATA[2] && !PWDATA[4]) || (PWDATA[3] && !PWDATA[2]))) // RULE4 RULE6
      || (wop == `DMC_OP_OFF && (!st_ff.dll_on || PWDATA[15:8] == 8'h00))
      || (wop == `DMC_OP_ON && (st_ff.dll_on || PWDATA[15:8] == 8'h00));

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.iss    = 1'b0;
    nxt_st.pready = 1'b0;
    if (st_ff.divcnt == 8'h00) begin
      nxt_st.ck     = ~st_ff.ck;
      nxt_st.ck_n   = st_ff.ck;
      nxt_st.divcnt = st_ff.div - 8'h01;
    end else begin
      nxt_st.divcnt = st_ff.divcnt - 8'h01;
    end
    // only bit 0 of each lane carries the pattern; upper lines may be copies
    nxt_st.dq_s1  = {DQ_IN[8], DQ_IN[0]}; // RULE1 RULE2
    nxt_st.dq_s2  = st_ff.dq_s1;
    nxt_st.dqs_s1 = DQS_IN;
    nxt_st.dqs_s2 = st_ff.dqs_s1;
    nxt_st.dqs_d  = st_ff.dqs_s2;
    // each strobe edge in the window is one beat until blen beats are in; preamble must hold low
    if (st_ff.cap && (st_ff.dqs_s2 != st_ff.dqs_d) && st_ff.beats < blen) begin // RULE25
      nxt_st.dl[idx] = st_ff.dq_s2[0];
      nxt_st.du[idx] = st_ff.dq_s2[1];
      nxt_st.beats   = st_ff.beats + 4'h1;
    end
    if (tick && st_ff.lock_c != 16'h0000) begin
      nxt_st.lock_c = st_ff.lock_c - 16'h0001;
      if (st_ff.lock_c == 16'h0001) begin
        nxt_st.locked = 1'b1; // RULE22
      end
    end
    if (tick) begin
      // idle uses deselect, inside a sequence nop fills the gaps
      nxt_st.pins = mk(st_ff.pins.cke, st_ff.busy ? `DMC_C_NOP : `DMC_C_DES,
                       3'h0, 14'h0000); // RULE12 RULE13
      if (st_ff.wait_c != 16'h0000) begin
        nxt_st.wait_c = st_ff.wait_c - 16'h0001;
      end else begin
        unique case (st_ff.state)
          ST_IDLE: begin
          end
          ST_M3ON: begin
            nxt_st.pins   = mk(1'b1, `DMC_C_MRS, 3'h3, `DMC_MR3_CAL); // RULE23
            nxt_st.iss    = 1'b1;
            nxt_st.cal_on = 1'b1;
            nxt_st.wait_c = `DMC_T_MOD - 16'h0001;
            nxt_st.state  = ST_RD;
          end
          ST_RD: begin
            nxt_st.pins   = mk(1'b1, `DMC_C_RD, 3'h0,
                               {1'b0, ~st_ff.chop, 9'h000, st_ff.half, 2'b00}); // RULE3 RULE4
            nxt_st.iss    = 1'b1;
            nxt_st.cap    = 1'b1;
            nxt_st.beats  = 4'h0;
            nxt_st.wait_c = `DMC_T_RDWIN - 16'h0001; // RULE8 RULE16
            nxt_st.state  = ST_M3OFF;
          end
          ST_M3OFF: begin
            nxt_st.cap    = 1'b0;
            nxt_st.pins   = mk(1'b1, `DMC_C_MRS, 3'h3, 14'h0000);
            nxt_st.iss    = 1'b1;
            nxt_st.cal_on = 1'b0;
            nxt_st.wait_c = `DMC_T_MOD - 16'h0001;
            nxt_st.state  = ST_END;
          end
          ST_MR1OFF: begin
            nxt_st.pins   = mk(1'b1, `DMC_C_MRS, 3'h1, `DMC_MR1_DLLOFF); // RULE17
            nxt_st.iss    = 1'b1;
            nxt_st.dll_on = 1'b0;
            nxt_st.locked = 1'b0;
            nxt_st.wait_c = `DMC_T_MOD - 16'h0001;
            nxt_st.state  = ST_SRE;
          end
          ST_SRE: begin
            nxt_st.pins   = mk(1'b0, `DMC_C_REF, 3'h0, 14'h0000); // RULE17 RULE20
            nxt_st.iss    = 1'b1;
            nxt_st.wait_c = `DMC_T_CKSRE - 16'h0001;
            nxt_st.state  = ST_FRQ;
          end
          ST_FRQ: begin
            // tCKSRX is counted on the new clock
            nxt_st.div    = st_ff.newdiv;
            nxt_st.wait_c = `DMC_T_CKSRX - 16'h0001; // RULE17 RULE20
            nxt_st.state  = ST_SRX;
          end
          ST_SRX: begin
            nxt_st.pins   = mk(1'b1, `DMC_C_NOP, 3'h0, 14'h0000);
            nxt_st.iss    = 1'b1;
            nxt_st.wait_c = TXS_NCK - 16'h0001; // RULE19 RULE21
            nxt_st.state  = (st_ff.op == `DMC_OP_ON) ? ST_MR1ON : ST_MR0;
          end
          ST_MR1ON: begin
            nxt_st.pins   = mk(1'b1, `DMC_C_MRS, 3'h1, 14'h0000); // RULE21
            nxt_st.iss    = 1'b1;
            nxt_st.dll_on = 1'b1;
            nxt_st.wait_c = `DMC_T_MRD - 16'h0001;
            nxt_st.state  = ST_DLLRST;
          end
          ST_DLLRST: begin
            nxt_st.pins   = mk(1'b1, `DMC_C_MRS, 3'h0,
                               `DMC_MR0_CL6 | `DMC_MR0_DLLRST); // RULE21
            nxt_st.iss    = 1'b1;
            nxt_st.lock_c = TDLLK_NCK; // RULE22
            nxt_st.wait_c = `DMC_T_MRD - 16'h0001;
            nxt_st.state  = ST_MR0;
          end
          ST_MR0: begin
            nxt_st.pins   = mk(1'b1, `DMC_C_MRS, 3'h0, `DMC_MR0_CL6
                               | (st_ff.otf ? `DMC_MR0_OTF : 14'h0000)); // RULE15 RULE19
            nxt_st.iss    = 1'b1;
            nxt_st.wait_c = `DMC_T_MRD - 16'h0001;
            nxt_st.state  = ST_MR2;
          end
          ST_MR2: begin
            nxt_st.pins   = mk(1'b1, `DMC_C_MRS, 3'h2, `DMC_MR2_CWL6); // RULE15
            nxt_st.iss    = 1'b1;
            nxt_st.wait_c = `DMC_T_MOD - 16'h0001; // RULE19 RULE22
            nxt_st.state  = ST_END;
          end
          ST_END: begin
            nxt_st.busy  = 1'b0;
            nxt_st.state = ST_IDLE;
          end
        endcase
      end
    end
    // answer one cycle after the access phase opens
    if (PSEL && PENABLE && !st_ff.pready) begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata  = 32'h0000_0000;
      unique case (PADDR)
        `DMC_A_CTRL: nxt_st.prdata = {16'h0000, st_ff.newdiv, 3'b000, st_ff.otf,
                                      st_ff.half, st_ff.chop, st_ff.op};
        `DMC_A_STAT: nxt_st.prdata = {8'h00, st_ff.du, st_ff.dl, 3'b000, st_ff.cal_on,
                                      st_ff.err, st_ff.locked, st_ff.dll_on, st_ff.busy};
        default:     nxt_st.pslverr = 1'b1;
      endcase
    end
    // writes act on the edge where the master sees ready
    if (PSEL && PENABLE && st_ff.pready && PWRITE) begin
      if (PADDR == `DMC_A_STAT && PWDATA[`DMC_F_ERR]) begin
        nxt_st.err = 1'b0;
      end
      if (PADDR == `DMC_A_CTRL && wop != 2'h0) begin
        if (refuse) begin
          nxt_st.err = 1'b1;
        end else begin
          nxt_st.op     = wop;
          nxt_st.chop   = PWDATA[2];
          nxt_st.half   = PWDATA[3];
          nxt_st.otf    = PWDATA[4];
          nxt_st.newdiv = PWDATA[15:8];
          nxt_st.busy   = 1'b1;
          nxt_st.wait_c = 16'h0000;
          if (wop == `DMC_OP_CAL) begin
            nxt_st.dl    = 8'h00;
            nxt_st.du    = 8'h00;
            nxt_st.state = ST_M3ON;
          end else begin
            nxt_st.state = (wop == `DMC_OP_OFF) ? ST_MR1OFF : ST_SRE;
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign PRDATA  = st_ff.prdata;
  assign PREADY  = st_ff.pready;
  assign PSLVERR = st_ff.pslverr;
  assign CK      = st_ff.ck;
  assign CK_N    = st_ff.ck_n;
  assign CKE     = st_ff.pins.cke;
  assign CS_N    = st_ff.pins.cs_n;
  assign RAS_N   = st_ff.pins.ras_n;
  assign CAS_N   = st_ff.pins.cas_n;
  assign WE_N    = st_ff.pins.we_n;
  assign BA      = st_ff.pins.ba;
  assign ADDR    = st_ff.pins.addr;
  assign ODT     = st_ff.pins.odt;

  // checking aids: CK cycles since the last mode register set and since exit
  logic [15:0] gap_ff;
  logic [15:0] xs_ff;
  logic        cke_ff;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      gap_ff <= 16'hffff;
      xs_ff  <= 16'hffff;
      cke_ff <= 1'b1;
    end else begin
      cke_ff <= st_ff.pins.cke;
      if (st_ff.iss && is_cmd(st_ff.pins, `DMC_C_MRS)) begin
        gap_ff <= 16'h0000;
      end else if (tick && gap_ff != 16'hffff) begin
        gap_ff <= gap_ff + 16'h0001;
      end
      if (st_ff.pins.cke && !cke_ff) begin
        xs_ff <= 16'h0000;
      end else if (tick && xs_ff != 16'hffff) begin
        xs_ff <= xs_ff + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  property p_rd_col;
    st_ff.iss && is_cmd(st_ff.pins, `DMC_C_RD) |-> st_ff.pins.addr[1:0] == 2'b00;
  endproperty
  a_rd_col: assert property (p_rd_col) // RULE3
    else $error("calibration read with nonzero column bits 1:0");
  property p_rd_bl8;
    st_ff.iss && is_cmd(st_ff.pins, `DMC_C_RD) && st_ff.pins.addr[12]
      |-> !st_ff.pins.addr[2];
  endproperty
  a_rd_bl8: assert property (p_rd_bl8) // RULE4
    else $error("eight-beat calibration read with address bit 2 set");
  property p_rd_lock;
    st_ff.iss && is_cmd(st_ff.pins, `DMC_C_RD) |-> st_ff.locked && st_ff.dll_on
      && st_ff.lock_c == 16'h0000;
  endproperty
  a_rd_lock: assert property (p_rd_lock) // RULE9
    else $error("calibration read before DLL lock");
  property p_rd_cal;
    st_ff.iss && is_cmd(st_ff.pins, `DMC_C_RD) |-> st_ff.cal_on && gap_ff >= `DMC_T_MOD;
  endproperty
  a_rd_cal: assert property (p_rd_cal) // RULE23
    else $error("read issued outside calibration mode");
  property p_rd_win;
    st_ff.iss && is_cmd(st_ff.pins, `DMC_C_RD) |-> st_ff.cap ##1 st_ff.cap [*3];
  endproperty
  a_rd_win: assert property (p_rd_win) // RULE8
    else $error("capture window closed too early");
  property p_sre_gap;
    st_ff.iss && is_cmd(st_ff.pins, `DMC_C_REF) && !st_ff.pins.cke
      |-> gap_ff >= `DMC_T_MOD && $past(st_ff.pins.cke);
  endproperty
  a_sre_gap: assert property (p_sre_gap) // RULE17
    else $error("self-refresh entered too soon after mode register set");
  property p_xs;
    st_ff.iss && is_cmd(st_ff.pins, `DMC_C_MRS) |-> xs_ff >= TXS_NCK;
  endproperty
  a_xs: assert property (p_xs) // RULE19
    else $error("mode register set before tXS after exit");
  property p_mrd;
    st_ff.iss && is_cmd(st_ff.pins, `DMC_C_MRS) |-> gap_ff >= `DMC_T_MRD;
  endproperty
  a_mrd: assert property (p_mrd) // RULE21
    else $error("mode register sets closer than tMRD");
  property p_cl6;
    st_ff.iss && is_cmd(st_ff.pins, `DMC_C_MRS) && !st_ff.dll_on && st_ff.pins.ba == 3'h0
      |-> (st_ff.pins.addr & `DMC_MR0_CLMSK) == `DMC_MR0_CL6;
  endproperty
  a_cl6: assert property (p_cl6) // RULE15
    else $error("DLL-off MR0 without CL 6");
  property p_cke_hold;
    $rose(st_ff.pins.cke) |-> (st_ff.pins.cke && !st_ff.pins.odt) throughout
      (##[1:1000] (st_ff.state == ST_IDLE));
  endproperty
  a_cke_hold: assert property (p_cke_hold) // RULE18
    else $error("CKE dropped or ODT raised before sequence end");
endmodule
`default_nettype wire

// ==== testbench/dmc_dev.sv ====
/*
  Behavioural memory for the calibration-read and DLL-switch controller:
  decodes commands, keeps mode registers and DLL state, returns the
  calibration pattern, and counts controller timing slips in viol.
  Assumes the controller makes CK and samples DQ/DQS with MCLK.
*/
`include "dmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dmc_dev #(
  parameter int       CL_NCK    = 6,
  parameter int       TMOD_NCK  = 12,
  parameter int       TMRD_NCK  = 4,
  parameter int       TXS_NCK   = 8,
  parameter int       TDLLK_NCK = 20,
  parameter bit [7:0] PAT_LOC0  = 8'hAA
) (
  input  wire logic        CK,    // memory clock
  input  wire logic        CKE,   // clock enable
  input  wire logic        CS_N,  // chip select
  input  wire logic        RAS_N, // row strobe
  input  wire logic        CAS_N, // column strobe
  input  wire logic        WE_N,  // write enable
  input  wire logic [2:0]  BA,    // bank address
  input  wire logic [13:0] ADDR,  // address
  input  wire logic        ODT,   // termination control
  output logic      [15:0] DQ,    // read data
  output logic             DQS,   // lower-lane read strobe
  output int               viol   // controller slips seen
);
  logic [13:0] mr0, mr1, mr3;
  logic [3:0]  cmd;
  logic        sr, chop;
  int          s_mrs, s_mr1, s_srx, lock_c, rd_lat, rd_first, rd_n;
  event        rd_ev;
  assign cmd = {CS_N, RAS_N, CAS_N, WE_N};
  initial begin
    mr0 = '0;
    mr1 = '0;
    mr3 = '0;
    sr = 1'b0;
    viol = 0;
    s_mrs = 100;
    s_mr1 = 100;
    s_srx = 100;
    lock_c = 1000;
    DQ = '0;
    DQS = 1'b0;
  end
  always @(posedge CK) begin
    s_mrs++;
    s_mr1++;
    s_srx++;
    lock_c++;
    if (ODT !== 1'b0) viol++;
    if (sr) begin
      if (CKE && cmd == `DMC_C_NOP) begin
        sr = 1'b0;
        s_srx = 0;
      end
    end else if (!CKE) begin
      if (cmd == `DMC_C_REF && s_mr1 >= TMOD_NCK) sr = 1'b1;
      else viol++;
    end else if (!CS_N && cmd != `DMC_C_NOP) begin
      if (s_srx < TXS_NCK) viol++;
      if (cmd == `DMC_C_MRS) begin
        if (s_mrs < TMRD_NCK) viol++;
        if (BA == 3'h0 && mr1[0] && (ADDR & `DMC_MR0_CLMSK) != `DMC_MR0_CL6) viol++;
        if (BA == 3'h0 && ADDR[8]) lock_c = 0;
        if (BA == 3'h0) mr0 = ADDR;
        if (BA == 3'h3) mr3 = ADDR;
        if (BA == 3'h1) begin
          mr1 = ADDR;
          s_mr1 = 0;
          if (ADDR[0]) lock_c = -1000000;
        end
        s_mrs = 0;
      end else if (cmd == `DMC_C_RD && mr3[2]) begin
        if (ADDR[1:0] != 2'b00 || lock_c < TDLLK_NCK || mr1[0]) viol++;
        chop = (mr0[1:0] == 2'b01) ? !ADDR[12] : (mr0[1:0] == 2'b10);
        if (!chop && ADDR[2]) viol++;
        rd_first = (chop && ADDR[2]) ? 4 : 0;
        rd_n = chop ? 4 : 8;
        rd_lat = mr1[0] ? CL_NCK - 1 : CL_NCK;
        -> rd_ev;
      end else viol++;
    end
  end
  // strobe edge lands mid-MCLK so it never races the controller's sampling
  always begin
    @(rd_ev);
    repeat (rd_lat) @(posedge CK);
    for (int j = 0; j < rd_n; j++) begin
      if (j != 0) @(CK);
      DQ = {7'h00, PAT_LOC0[rd_first + j], {8{PAT_LOC0[rd_first + j]}}};
      #12 DQS = ~DQS;
    end
    @(CK);
    DQ = ~DQ;
  end
endmodule
`default_nettype wire

// ==== testbench/dmc_host_tb_top.sv ====
/*
  Self-checking bench of the calibration-read and DLL-switch controller.
  Assumes dmc_dev on the memory pins and APB orders from this module.
*/
`include "dmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dmc_host_tb_top
  import dmc_pkg::*;
;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0]  st;  // {err, locked, dll_on}
    logic        chk; // pattern compared
    logic [15:0] pat;
  } dmc_row_s;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic        ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dqs;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic [15:0] dq;
  int          n_fail, n_compared, viol;
  dmc_row_s    rows [10] = '{
    '{32'h0000_0001, 3'b011, 1'b1, 16'hAAAA}, // eight beats
    '{32'h0000_0812, 3'b000, 1'b0, 16'h0000}, // dll off, slower clock
    '{32'h0000_0001, 3'b100, 1'b0, 16'h0000}, // read with dll off
    '{32'h0000_0413, 3'b011, 1'b0, 16'h0000}, // dll on
    '{32'h0000_0015, 3'b011, 1'b1, 16'h0A0A}, // chop, lower half
    '{32'h0000_001D, 3'b011, 1'b1, 16'hA0A0}, // chop, upper half
    '{32'h0000_0005, 3'b111, 1'b0, 16'h0000}, // chop without otf
    '{32'h0000_0019, 3'b111, 1'b0, 16'h0000}, // half without chop
    '{32'h0000_0413, 3'b111, 1'b0, 16'h0000}, // dll on while on
    '{32'h0000_0012, 3'b111, 1'b0, 16'h0000}  // zero divider
  };
  dmc_host #(.TXS_NCK(16'h0008), .TDLLK_NCK(16'h0014)) u_dmc_host (
    .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CK(ck), .CK_N(ck_n), .CKE(cke), .CS_N(cs_n),
    .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr),
    .ODT(odt), .DQ_IN(dq), .DQS_IN(dqs));
  dmc_dev #(.TXS_NCK(8), .TDLLK_NCK(20)) u_dmc_dev (
    .CK(ck), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n),
    .WE_N(we_n), .BA(ba), .ADDR(addr), .ODT(odt), .DQ(dq), .DQS(dqs),
    .viol(viol));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // entered just after a rising edge; leaves one idle cycle behind it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    e = pslverr;
    if (n >= 100) cmp(32'h0, 32'h1, "apb answer");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_done(input logic lck);
    int n;
    n = 0;
    do begin
      apb(1'b0, `DMC_A_STAT, 32'h0);
      n++;
    end while ((rd[0] !== 1'b0 || rd[2] !== lck) && n < 1000);
    if (rd[0] !== 1'b0 || rd[2] !== lck) cmp(32'h0, 32'h1, "status wait");
    st = rd;
  endtask
  initial begin
    n_fail = 0;
    n_compared = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cmp(32'({pready, ck, ck_n, cke, cs_n, odt}), 32'h0000_000E, "reset pins");
    apb(1'b0, `DMC_A_STAT, 32'h0);
    cmp(rd, 32'h0000_0006, "status after reset");
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, `DMC_A_CTRL, rows[i].ctrl);
      wait_done(rows[i].st[1]);
      cmp(32'(st[4:0]), 32'({1'b0, rows[i].st, 1'b0}), "status bits");
      if (rows[i].chk) cmp(32'(st[23:8]), 32'(rows[i].pat), "pattern");
      // the last nop of a sequence stands one CK after busy clears
      repeat (20) @(posedge mclk);
      cmp(32'(cs_n), 32'h1, "idle deselect");
      apb(1'b1, `DMC_A_STAT, 32'h0000_0008);
      $display("row %0d done", i);
    end
    apb(1'b0, `DMC_A_CTRL, 32'h0);
    cmp(rd, 32'h0000_001D, "refused orders keep control");
    apb(1'b0, 12'h008, 32'h0);
    cmp(32'(e), 32'h1, "unmapped read error");
    cmp(rd, 32'h0, "unmapped read data");
    apb(1'b1, 12'h00C, 32'h0000_0001);
    cmp(32'(e), 32'h1, "unmapped write error");
    apb(1'b0, `DMC_A_STAT, 32'h0);
    cmp(32'(rd[0]), 32'h0, "unmapped write ignored");
    $display("unmapped test done");
    // second order arrives while the first read is still running
    apb(1'b1, `DMC_A_CTRL, 32'h0000_0001);
    apb(1'b1, `DMC_A_CTRL, 32'h0000_0812);
    wait_done(1'b1);
    cmp(32'(st[3:0]), 32'h0000_000E, "busy refusal");
    cmp(32'(st[23:8]), 32'h0000_AAAA, "pattern after refusal");
    apb(1'b1, `DMC_A_STAT, 32'h0000_0008);
    apb(1'b0, `DMC_A_STAT, 32'h0);
    cmp(32'(rd[3:0]), 32'h0000_0006, "error cleared");
    $display("busy test done");
    cmp(32'(viol), 32'h0, "memory-side timing");
    report_and_stop();
  end
  initial begin
    repeat (80000) @(posedge mclk);
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
